// ===== bench/lapd_msg_tx_props.sv
// Port assertions for the message transmitter.
// Assumes one clock domain; bound to every lapd_msg_tx.
`timescale 1ns/100ps
module lapd_msg_tx_props #(
    parameter int RETX_CYCLES = lapd_tx_pkg::RETX_CYCLES
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       tx_enable,
    input wire logic       link_byte_select,
    input wire logic       auto_retransmit,
    input wire logic       send_cmd,
    input wire logic       oh_bit_strobe,
    input wire logic       oh_in_nr,
    input wire logic       oh_in_gc,
    input wire logic [2:0] oh_bit_index,
    input wire logic [7:0] nr_reg_byte,
    input wire logic [7:0] gc_reg_byte,
    input wire logic       oh_bit_out,
    input wire logic       busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic  nr_bit = nr_reg_byte[oh_bit_index];
    wire logic  gc_bit = gc_reg_byte[oh_bit_index];
    wire logic  fl_bit = lapd_tx_pkg::FLAG_OCTET[oh_bit_index];
    logic [8:0] idle_reg;
    int         gap_reg;
    // Idle length and retransmit gap counters
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_reg <= '0;
            gap_reg  <= 0;
        end else begin
            idle_reg <= (tx_enable || busy) ? 9'h000 : idle_reg + {8'h00, idle_reg != 9'h1ff};
            gap_reg  <= (busy || !auto_retransmit || !tx_enable) ? 0
                      : (gap_reg != 0 || $fell(busy)) ? gap_reg + 1 : 0;
        end
    end
    sequence s_nr_slot; oh_bit_strobe && oh_in_nr && !link_byte_select; endsequence
    sequence s_gc_slot; oh_bit_strobe && oh_in_gc && link_byte_select; endsequence
    sequence s_off; !tx_enable [*4] ##0 !busy; endsequence
    sequence s_done; $fell(busy) && !auto_retransmit ##1 !send_cmd [*8]; endsequence
    property p_nr_reg; s_nr_slot |=> oh_bit_out == $past(nr_bit); endproperty
    property p_gc_reg; s_gc_slot |=> oh_bit_out == $past(gc_bit); endproperty
    property p_idle_flag;
        oh_bit_strobe && (oh_in_nr == link_byte_select) && idle_reg == 9'h1ff
            |=> oh_bit_out == $past(fl_bit);
    endproperty
    property p_hold; !oh_bit_strobe |=> $stable(oh_bit_out); endproperty
    // Start waits for a free buffer entry, one octet time at most
    property p_start; send_cmd && tx_enable && !busy |-> ##[1:40] busy; endproperty
    property p_off; s_off |=> !busy; endproperty
    property p_once; s_done |=> !busy; endproperty
    property p_retx; gap_reg <= RETX_CYCLES + 16; endproperty
    a_nr_reg: assert property (p_nr_reg)
        else $error("NR slot lost its register bit");
    a_gc_reg: assert property (p_gc_reg)
        else $error("GC slot lost its register bit");
    a_idle_flag: assert property (p_idle_flag)
        else $error("idle link bit is not a flag bit");
    a_hold: assert property (p_hold)
        else $error("link bit changed without a slot");
    a_start: assert property (p_start)
        else $error("send command did not start a frame");
    a_off: assert property (p_off)
        else $error("disabled transmitter started");
    a_once: assert property (p_once)
        else $error("single shot frame repeated");
    a_retx: assert property (p_retx)
        else $error("retransmission overdue");
endmodule
bind lapd_msg_tx lapd_msg_tx_props #(.RETX_CYCLES(RETX_CYCLES)) i_props (
    .clk, .rst_n, .tx_enable, .link_byte_select, .auto_retransmit, .send_cmd, .oh_bit_strobe,
    .oh_in_nr, .oh_in_gc, .oh_bit_index, .nr_reg_byte, .gc_reg_byte, .oh_bit_out, .busy);

// ===== bench/lapd_remote_rx.sv
// Remote receiver: makes overhead slots, strips flags and stuffed zeros.
// Assumes the slot bit is valid in the cycle after its strobe.
`timescale 1ns/100ps
module lapd_remote_rx (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       sel,
    input  wire logic       oh_bit_out,
    output logic            oh_bit_strobe,
    output logic            oh_in_nr,
    output logic            oh_in_gc,
    output logic [2:0]      oh_bit_index,
    output logic            oct_valid,
    output logic [7:0]      oct_data,
    output logic            frame_end,
    output logic [7:0]      other_byte
);
    logic [4:0]      slot_reg;
    logic [7:0]      raw_reg, dat_reg, oth_reg;
    logic [3:0]      ones_reg;
    logic [2:0]      cnt_reg;
    logic            open_reg, got_reg;
    wire logic [7:0] raw_next = {raw_reg[6:0], oh_bit_out};
    wire logic       msg = slot_reg[4] ^ sel;
    assign oh_bit_strobe = rst_n && !slot_reg[0];
    assign oh_in_nr      = !slot_reg[4];
    assign oh_in_gc      = slot_reg[4];
    assign oh_bit_index  = ~slot_reg[3:1];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {slot_reg, raw_reg, dat_reg, oth_reg, ones_reg, cnt_reg, open_reg, got_reg} <= '0;
            {oct_valid, oct_data, frame_end, other_byte} <= '0;
        end else begin
            slot_reg  <= slot_reg + 5'h01;
            oct_valid <= 1'b0;
            frame_end <= 1'b0;
            if (slot_reg[0] && !msg) begin
                oth_reg <= {oth_reg[6:0], oh_bit_out};
                if (slot_reg[3:1] == 3'h7) other_byte <= {oth_reg[6:0], oh_bit_out};
            end else if (slot_reg[0]) begin
                raw_reg  <= raw_next;
                ones_reg <= oh_bit_out ? ones_reg + 4'h1 : 4'h0;
                if (raw_next == 8'h7e) begin
                    frame_end <= got_reg;
                    {open_reg, got_reg, cnt_reg} <= 5'b10000;
                end else if (!(ones_reg == 4'h5 && !oh_bit_out)) begin
                    dat_reg <= {dat_reg[6:0], oh_bit_out};
                    cnt_reg <= cnt_reg + 3'h1;
                    if (cnt_reg == 3'h7 && open_reg) begin
                        oct_valid <= 1'b1;
                        oct_data  <= {dat_reg[6:0], oh_bit_out};
                        got_reg   <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the message transmitter.
// Assumes the receiver model and the bound checker.
`timescale 1ns/100ps
module testbench;
    localparam int RETX = 6000;
    logic       clk = 1'b0, rst_n = 1'b0, buf_wr_en = 1'b0, tx_enable = 1'b0, send_cmd = 1'b0;
    logic       payload_size_select = 1'b0, link_byte_select = 1'b0, auto_retransmit = 1'b0;
    logic       response_bit = 1'b0, oh_bit_strobe, oh_in_nr, oh_in_gc, oh_bit_out, busy;
    logic       oct_valid, frame_end;
    logic [2:0] oh_bit_index;
    logic [7:0] buf_wr_addr = 8'h00, buf_wr_data = 8'h00, nr_reg_byte = 8'hc3;
    logic [7:0] gc_reg_byte = 8'h00, oct_data, other_byte, pay[88], rx_q[$], exp_q[$];
    int         failures = 0, compares = 0, frames = 0;
    always #20 clk = ~clk;
    lapd_msg_tx #(.RETX_CYCLES(RETX)) i_dut (.clk, .rst_n, .buf_wr_en, .buf_wr_addr,
        .buf_wr_data, .tx_enable, .payload_size_select, .link_byte_select, .auto_retransmit,
        .response_bit, .send_cmd, .oh_bit_strobe, .oh_in_nr, .oh_in_gc, .nr_reg_byte,
        .oh_bit_index, .gc_reg_byte, .oh_bit_out, .busy);
    lapd_remote_rx i_rx (.clk, .rst_n, .sel(link_byte_select), .oh_bit_out, .oh_bit_strobe,
        .oh_in_nr, .oh_in_gc, .oh_bit_index, .oct_valid, .oct_data, .frame_end, .other_byte);
    always @(posedge clk) begin
        if (oct_valid === 1'b1) rx_q.push_back(oct_data);
        if (frame_end === 1'b1) frames++;
    end
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            failures++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic finish_test;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
        for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        return c;
    endfunction
    task automatic wait_frames(input int n, input int lim);
        for (int k = 0; k < lim && frames < n; k++) @(posedge clk);
        check(frames >= n, "frame not received");
    endtask
    task automatic cmp_frame;
        check(rx_q.size() == exp_q.size(), "frame length");
        foreach (exp_q[i]) check(rx_q[i] === exp_q[i], "frame octet");
    endtask
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_frame(input logic [7:0] mt, input logic sz, sel, resp, rt);
        logic [15:0] c;
        int          n;
        c = 16'hffff;
        for (int a = 0; a < 88; a++) begin
            pay[a] = (a == 0) ? mt : (a % 3 == 1) ? 8'hff : (a % 3 == 2) ? 8'h7e : 8'(a);
            @(posedge clk);
            buf_wr_en   <= 1'b1;
            buf_wr_addr <= 8'h86 + 8'(a);
            buf_wr_data <= pay[a];
        end
        @(posedge clk);
        buf_wr_en           <= 1'b0;
        payload_size_select <= sz;
        link_byte_select    <= sel;
        response_bit        <= resp;
        auto_retransmit     <= rt;
        nr_reg_byte         <= mt ^ 8'h5a;
        gc_reg_byte         <= ~mt;
        tx_enable           <= 1'b1;
        repeat (300) @(posedge clk);
        exp_q = {resp ? 8'h3e : 8'h3c, 8'h01, 8'h03};
        for (int i = 0; i < (sz ? 82 : 76); i++) exp_q.push_back(pay[i]);
        foreach (exp_q[i]) c = crc(c, exp_q[i]);
        exp_q.push_back(~c[15:8]);
        exp_q.push_back(~c[7:0]);
        rx_q.delete();
        send_cmd <= 1'b1;
        @(posedge clk);
        send_cmd <= 1'b0;
        wait_frames(frames + 1, 8000);
        cmp_frame();
        check(rx_q[0][7:2] === 6'h0f, "service point id");
        check(other_byte === (sel ? gc_reg_byte : nr_reg_byte), "register byte");
        if (!rt) begin
            n = frames;
            repeat (800) @(posedge clk);
            check(frames == n && busy === 1'b0, "single frame repeated");
        end
    endtask
    task automatic t_disabled;
        send_cmd <= 1'b1;
        @(posedge clk);
        send_cmd <= 1'b0;
        repeat (1000) @(posedge clk);
        check(busy === 1'b0 && frames == 0 && other_byte === 8'hc3, "disabled link");
    endtask
    task automatic t_retx;
        int n;
        t_frame(8'h38, 1'b0, 1'b1, 1'b0, 1'b1);
        rx_q.delete();
        wait_frames(frames + 1, RETX + 8000);
        cmp_frame();
        auto_retransmit <= 1'b0;
        for (int k = 0; k < RETX + 8000 && busy !== 1'b0; k++) @(posedge clk);
        repeat (600) @(posedge clk);
        n = frames;
        repeat (RETX + 4000) @(posedge clk);
        check(frames == n, "frame sent after stop");
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        $display("BAD %0t watchdog expired", $time);
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        t_disabled();
        t_frame(8'h38, 1'b0, 1'b0, 1'b0, 1'b0);
        t_frame(8'h34, 1'b0, 1'b1, 1'b1, 1'b0);
        t_frame(8'h32, 1'b0, 1'b0, 1'b1, 1'b0);
        t_frame(8'h3f, 1'b1, 1'b1, 1'b0, 1'b0);
        t_retx();
        finish_test();
    end
endmodule

// ===== core/lapd_msg_tx.sv
// E3 path maintenance link message transmitter: frames the buffered payload as
// an unnumbered LAP-D frame and shifts it bit by bit into the NR or GC byte.
// Assumes the overhead slot strobes come from the transmit framer on clk.
`timescale 1ns/100ps
module lapd_msg_tx #(
    parameter int RETX_CYCLES = lapd_tx_pkg::RETX_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       buf_wr_en,
    input  wire logic [7:0] buf_wr_addr,
    input  wire logic [7:0] buf_wr_data,
    input  wire logic       tx_enable,
    input  wire logic       payload_size_select,
    input  wire logic       link_byte_select,
    input  wire logic       auto_retransmit,
    input  wire logic       response_bit,
    input  wire logic       send_cmd,
    input  wire logic       oh_bit_strobe,
    input  wire logic       oh_in_nr,
    input  wire logic       oh_in_gc,
    input  wire logic [7:0] nr_reg_byte,
    input  wire logic [2:0] oh_bit_index,
    input  wire logic [7:0] gc_reg_byte,
    output logic            oh_bit_out,
    output logic            busy
);
    // ------------------------------------------------------------
    // Message buffer
    // ------------------------------------------------------------
    logic [7:0] msg_mem [lapd_tx_pkg::BUF_DEPTH];
    wire  [7:0] wr_off    = buf_wr_addr - lapd_tx_pkg::BUF_BASE_ADDR;
    wire        wr_hit    = buf_wr_en && (buf_wr_addr >= lapd_tx_pkg::BUF_BASE_ADDR)
                            && (buf_wr_addr <= lapd_tx_pkg::BUF_LAST_ADDR);
    always_ff @(posedge clk) begin
        if (wr_hit) begin
            msg_mem[wr_off[6:0]] <= buf_wr_data;
        end
    end

    // ------------------------------------------------------------
    // Octet sequencer
    // ------------------------------------------------------------
    lapd_tx_pkg::tx_state_t state_reg;
    lapd_tx_pkg::tx_state_t state_next;
    logic [6:0]  idx_reg;
    logic [15:0] crc_reg;
    logic [31:0] timer_reg;
    logic        pend_reg;
    logic        size_reg;
    wire         q_ready;
    wire  [6:0]  pay_len  = size_reg ? lapd_tx_pkg::PAYLOAD_LONG
                                     : lapd_tx_pkg::PAYLOAD_SHORT;
    wire  [7:0]  addr_oct = response_bit ? lapd_tx_pkg::ADDR_RSP_OCTET
                                         : lapd_tx_pkg::ADDR_CMD_OCTET;
    wire  [7:0]  addr_chk = {lapd_tx_pkg::SAPI_VALUE, addr_oct[1:0]};
    wire  [7:0]  tei_oct  = {lapd_tx_pkg::TEI_VALUE, 1'b1};
    wire  [7:0]  hdr_oct  = (idx_reg == 7'd0) ? addr_chk :
                            (idx_reg == 7'd1) ? tei_oct :
                                                lapd_tx_pkg::CONTROL_OCTET;
    wire  [7:0]  pay_oct  = msg_mem[idx_reg];
    wire  [15:0] fcs      = ~crc_reg;
    wire  [7:0]  q_oct    = (state_reg == lapd_tx_pkg::ST_HDR)    ? hdr_oct :
                            (state_reg == lapd_tx_pkg::ST_PAY)    ? pay_oct :
                            (state_reg == lapd_tx_pkg::ST_FCS_HI) ? fcs[15:8] :
                            (state_reg == lapd_tx_pkg::ST_FCS_LO) ? fcs[7:0] :
                                                                    lapd_tx_pkg::FLAG_OCTET;
    // Flags are sent raw, everything else is stuffed
    wire         q_stuff  = (state_reg == lapd_tx_pkg::ST_HDR) ||
                            (state_reg == lapd_tx_pkg::ST_PAY) ||
                            (state_reg == lapd_tx_pkg::ST_FCS_HI) ||
                            (state_reg == lapd_tx_pkg::ST_FCS_LO);
    wire         q_push   = q_ready && tx_enable;
    wire         crc_take = q_push && ((state_reg == lapd_tx_pkg::ST_HDR) ||
                                       (state_reg == lapd_tx_pkg::ST_PAY));
    wire         timer_hit = (timer_reg >= RETX_CYCLES - 1);
    // Timer hit lasts one cycle, so it is held as a pending send
    wire         retx_due = auto_retransmit && timer_hit;
    wire         start    = pend_reg;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ lapd_tx_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            lapd_tx_pkg::ST_IDLE:   if (start) state_next = lapd_tx_pkg::ST_HDR;
            lapd_tx_pkg::ST_HDR:    if (idx_reg == 7'd2) state_next = lapd_tx_pkg::ST_PAY;
            lapd_tx_pkg::ST_PAY:    if (idx_reg == pay_len - 7'd1) state_next = lapd_tx_pkg::ST_FCS_HI;
            lapd_tx_pkg::ST_FCS_HI: state_next = lapd_tx_pkg::ST_FCS_LO;
            lapd_tx_pkg::ST_FCS_LO: state_next = lapd_tx_pkg::ST_CLOSE;
            lapd_tx_pkg::ST_CLOSE:  state_next = lapd_tx_pkg::ST_IDLE;
            default:                state_next = lapd_tx_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= lapd_tx_pkg::ST_IDLE;
            idx_reg   <= 7'd0;
            crc_reg   <= lapd_tx_pkg::CRC_INIT;
            size_reg  <= 1'b0;
        end else if (!tx_enable) begin
            state_reg <= lapd_tx_pkg::ST_IDLE;
            idx_reg   <= 7'd0;
        end else if (q_push) begin
            state_reg <= state_next;
            if (state_next != state_reg) idx_reg <= 7'd0;
            else idx_reg <= idx_reg + 7'd1;
            if (state_reg == lapd_tx_pkg::ST_IDLE) begin
                crc_reg  <= lapd_tx_pkg::CRC_INIT;
                size_reg <= payload_size_select;
            end else if (crc_take) begin
                crc_reg <= crc_step(crc_reg, q_oct);
            end
        end
    end

    // Send request and one-second repeat timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg  <= 1'b0;
            timer_reg <= 32'd0;
        end else begin
            if ((send_cmd && tx_enable) || retx_due) pend_reg <= 1'b1;
            else if (q_push && state_reg == lapd_tx_pkg::ST_IDLE && start) pend_reg <= 1'b0;
            if (!tx_enable || !auto_retransmit || timer_hit) timer_reg <= 32'd0;
            else timer_reg <= timer_reg + 32'd1;
        end
    end

    // ------------------------------------------------------------
    // Octet buffer and bit serialiser
    // ------------------------------------------------------------
    wire  [8:0] b_data;
    wire        b_valid;
    logic [7:0] sh_reg;
    logic [3:0] left_reg;
    logic       stuff_reg;
    logic [2:0] ones_reg;
    logic       pend_zero_reg;
    wire        slot      = oh_bit_strobe && (link_byte_select ? oh_in_nr : oh_in_gc);
    wire        load      = slot && (left_reg == 4'd0) && !pend_zero_reg;
    wire        have_bit  = (left_reg != 4'd0) || pend_zero_reg || b_valid;
    wire [7:0]  cur_oct   = (left_reg != 4'd0) ? sh_reg : b_data[7:0];
    wire        cur_stuff = (left_reg != 4'd0) ? stuff_reg : b_data[8];
    wire        data_bit  = pend_zero_reg ? 1'b0 : (have_bit ? cur_oct[7] : 1'b0);
    wire        idle_bit  = lapd_tx_pkg::FLAG_OCTET[oh_bit_index];
    wire        msg_bit   = have_bit ? data_bit : idle_bit;
    wire        nr_bit    = nr_reg_byte[oh_bit_index];
    wire        gc_bit    = gc_reg_byte[oh_bit_index];
    wire        line_bit  = link_byte_select ? (oh_in_nr ? msg_bit : gc_bit)
                                             : (oh_in_gc ? msg_bit : nr_bit);
    wire        emit_data = slot && !pend_zero_reg && ((left_reg != 4'd0) || b_valid);
    wire        hit_five  = cur_stuff && cur_oct[7] && (ones_reg == lapd_tx_pkg::ONES_LIMIT - 3'd1);

    lapd_skid_buf #(
        .WIDTH (9)
    ) u_octet_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   ({q_stuff, q_oct}),
        .in_valid  (tx_enable),
        .in_ready  (q_ready),
        .out_data  (b_data),
        .out_valid (b_valid),
        .out_ready (load)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_reg        <= 8'h00;
            left_reg      <= 4'd0;
            stuff_reg     <= 1'b0;
            ones_reg      <= 3'd0;
            pend_zero_reg <= 1'b0;
        end else if (slot) begin
            if (pend_zero_reg) begin
                pend_zero_reg <= 1'b0;
                ones_reg      <= 3'd0;
            end else if (emit_data) begin
                sh_reg        <= {cur_oct[6:0], 1'b0};
                left_reg      <= ((left_reg != 4'd0) ? left_reg : 4'd8) - 4'd1;
                stuff_reg     <= cur_stuff;
                pend_zero_reg <= hit_five;
                ones_reg      <= (!cur_stuff || !cur_oct[7]) ? 3'd0 : ones_reg + 3'd1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oh_bit_out <= 1'b0;
            busy       <= 1'b0;
        end else begin
            if (oh_bit_strobe) oh_bit_out <= line_bit;
            busy <= (state_reg != lapd_tx_pkg::ST_IDLE);
        end
    end
endmodule

// ===== core/lapd_skid_buf.sv
// Two-entry valid/ready buffer for octets.
// Assumes the same clock and reset as the framer.
`timescale 1ns/100ps
module lapd_skid_buf #(
    parameter int WIDTH = 9
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] mem_reg [2];
    logic             wr_ptr_reg;
    logic             rd_ptr_reg;
    logic [1:0]       count_reg;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count_reg != 2'd2);
    assign out_valid = (count_reg != 2'd0);
    assign out_data  = mem_reg[rd_ptr_reg];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'd0;
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data;
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// ===== core/lapd_tx_pkg.sv
// Constants for the E3 path maintenance link message transmitter.
// Assumes a single 25 MHz clock domain.
package lapd_tx_pkg;
    localparam logic [7:0]  FLAG_OCTET       = 8'h7e;
    localparam logic [5:0]  SAPI_VALUE       = 6'h0f;
    localparam logic [7:0]  ADDR_CMD_OCTET   = 8'h3c;
    localparam logic [7:0]  ADDR_RSP_OCTET   = 8'h3e;
    localparam logic [6:0]  TEI_VALUE        = 7'h00;
    localparam logic [7:0]  TEI_OCTET        = 8'h01;
    localparam logic [7:0]  CONTROL_OCTET    = 8'h03;
    localparam logic [15:0] CRC_POLY         = 16'h1021;
    localparam logic [15:0] CRC_INIT         = 16'hffff;
    localparam logic [7:0]  BUF_BASE_ADDR    = 8'h86;
    localparam logic [7:0]  BUF_LAST_ADDR    = 8'hdd;
    localparam int          BUF_DEPTH        = 88;
    localparam logic [6:0]  PAYLOAD_SHORT    = 7'd76;
    localparam logic [6:0]  PAYLOAD_LONG     = 7'd82;
    localparam int          CLK_HZ           = 25_000_000;
    localparam int          RETX_PERIOD_S    = 1;
    localparam int          RETX_CYCLES      = CLK_HZ * RETX_PERIOD_S;
    localparam logic [2:0]  ONES_LIMIT       = 3'd5;
    typedef enum logic [2:0] {
        ST_IDLE, ST_HDR, ST_PAY, ST_FCS_HI, ST_FCS_LO, ST_CLOSE, ST_WAIT
    } tx_state_t;
endpackage
